// ---- hw/spid_pkg.sv ----
package spid_pkg;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned DEB_TIME_NS   = 1000;
   localparam int unsigned DEB_CYCLES    = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [4:0]  DEB_LIMIT     = 5'(DEB_CYCLES);
   localparam int unsigned IDLE_TIME_US  = 50000;
   localparam int unsigned IDLE_CYCLES   = (IDLE_TIME_US * 1000) / CLK_PERIOD_NS;

   // ************************************************************
   // Register map (byte addresses)
   // ************************************************************
   localparam logic [7:0] ADR_CTRL   = 8'h00;
   localparam logic [7:0] ADR_PRESET = 8'h04;
   localparam logic [7:0] ADR_IDLE   = 8'h08;
   localparam logic [7:0] ADR_STATUS = 8'h0C;
   localparam logic [7:0] ADR_POS    = 8'h10;

   // ************************************************************
   // Field positions and reset values
   // ************************************************************
   localparam int unsigned CTRL_MODE_BIT  = 0;
   localparam int unsigned PRESET_A_LSB   = 0;
   localparam int unsigned PRESET_B_LSB   = 4;
   localparam int unsigned STAT_COLL_BIT  = 7;
   localparam logic [3:0]  PRESET_A_RST   = 4'h0;
   localparam logic [3:0]  PRESET_B_RST   = 4'h0;
   localparam logic [31:0] POS_RST        = 32'h0000_0000;

   // ************************************************************
   // Filtered input indexes
   // ************************************************************
   localparam int unsigned NUM_IN  = 5;
   localparam int unsigned IDX_A   = 0;
   localparam int unsigned IDX_B   = 1;
   localparam int unsigned IDX_REL = 2;
   localparam int unsigned IDX_SEL = 3;
   localparam int unsigned IDX_OVR = 4;

   typedef enum logic
   {
      MODE_ONE_PULSE = 1'b0,
      MODE_TWO_PULSE = 1'b1
   } spid_mode_e;

endpackage : spid_pkg

// ---- hw/spid_filter.sv ----
`timescale 1ns/10ps
module spid_filter
   import spid_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic sys_rst,
   input  wire logic clk_en,
   input  wire logic raw,
   output logic      level
);

   logic       sync1_q;
   logic       sync1_d;
   logic       sync2_q;
   logic       sync2_d;
   logic [4:0] cnt_q;
   logic [4:0] cnt_d;
   logic       level_q;
   logic       level_d;

   // Level changes only after DEB_LIMIT stable samples
   always_comb
   begin
      sync1_d = raw;
      sync2_d = sync1_q;
      level_d = level_q;
      cnt_d   = 5'h00;
      if (sync2_q != level_q)
      begin
         if (cnt_q == DEB_LIMIT - 5'h01)
            level_d = sync2_q;
         else
            cnt_d = cnt_q + 5'h01;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         cnt_q   <= 5'h00;
         level_q <= 1'b0;
      end
      else if (clk_en)
      begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         cnt_q   <= cnt_d;
         level_q <= level_d;
      end
   end

   assign level = level_q;

endmodule : spid_filter

// ---- hw/spid_decoder.sv ----
// Decided for this implementation: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
// How it works
// - Mode bit picks step/dir or forward/reverse
// - One-pulse, direction on: falling step advances
// - One-pulse, direction off: falling step retracts
// - Input high means optocoupler conducting
// - Reduced current only while pulse lines idle
// - Two-pulse: forward advances, reverse retracts
// - Release input removes winding current
// - Size select picks preset b, else a
module spid_decoder
   import spid_pkg::*;
#(
   parameter int unsigned IDLE_RST_CYCLES = IDLE_CYCLES
)
(
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic        clk_en,
   input  wire logic        wb_cyc,
   input  wire logic        wb_stb,
   input  wire logic        wb_we,
   input  wire logic [7:0]  wb_adr,
   input  wire logic [3:0]  wb_sel,
   input  wire logic [31:0] wb_dat_w,
   output logic      [31:0] wb_dat_r,
   output logic             wb_ack,
   input  wire logic        step_pulse_in,
   input  wire logic        direction_in,
   input  wire logic        winding_release_in,
   input  wire logic        step_size_sel_in,
   input  wire logic        idle_current_cutback_override_in,
   output logic             step_fwd,
   output logic             step_rev,
   output logic             winding_en,
   output logic             current_cutback,
   output logic      [3:0]  step_size_sel
);

   // ************************************************************
   // Input filters
   // ************************************************************
   logic [NUM_IN-1:0] raw_in;
   logic [NUM_IN-1:0] filt;

   // Pin level 1 is the conducting state on every input
   assign raw_in = {idle_current_cutback_override_in, step_size_sel_in,
                    winding_release_in, direction_in, step_pulse_in};

   genvar gi;
   generate
      for (gi = 0; gi < NUM_IN; gi++)
      begin : g_filt
         spid_filter u_filt
         (
            .core_clk (core_clk),
            .sys_rst  (sys_rst),
            .clk_en   (clk_en),
            .raw      (raw_in[gi]),
            .level    (filt[gi])
         );
      end
   endgenerate

   // ************************************************************
   // Register file state
   // ************************************************************
   spid_mode_e  mode_q;
   spid_mode_e  mode_d;
   logic [3:0]  preset_a_q;
   logic [3:0]  preset_a_d;
   logic [3:0]  preset_b_q;
   logic [3:0]  preset_b_d;
   logic [23:0] idle_lim_q;
   logic [23:0] idle_lim_d;
   logic [31:0] pos_q;
   logic [31:0] pos_d;
   logic        coll_q;
   logic        coll_d;
   logic        ack_q;
   logic        ack_d;
   logic [31:0] rdat_q;
   logic [31:0] rdat_d;

   // ************************************************************
   // Step decode state
   // ************************************************************
   logic        prev_a_q;
   logic        prev_b_q;
   logic        fwd_q;
   logic        fwd_d;
   logic        rev_q;
   logic        rev_d;
   logic        wind_q;
   logic        wind_d;
   logic        cut_q;
   logic        cut_d;
   logic [23:0] idle_cnt_q;
   logic [23:0] idle_cnt_d;
   logic [3:0]  res_q;
   logic [3:0]  res_d;
   logic        fall_a;
   logic        fall_b;
   logic        chg_b;
   logic        busy;
   logic        coll_ev;
   logic        bus_wr;

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
            res[b*8 +: 8] = new_v[b*8 +: 8];
      end
      return res;
   endfunction : merge

   // ************************************************************
   // Edge decode
   // ************************************************************
   assign fall_a = prev_a_q & ~filt[IDX_A];
   assign fall_b = prev_b_q & ~filt[IDX_B];
   assign chg_b  = prev_b_q ^ filt[IDX_B];

   always_comb
   begin
      fwd_d   = 1'b0;
      rev_d   = 1'b0;
      coll_ev = 1'b0;
      if (mode_q == MODE_ONE_PULSE)
      begin
         fwd_d   = fall_a & filt[IDX_B];
         rev_d   = fall_a & ~filt[IDX_B];
         // Direction taken as filtered now; a coincident change is flagged
         coll_ev = fall_a & chg_b;
      end
      else
      begin
         fwd_d   = fall_a & ~filt[IDX_B] & ~fall_b;
         rev_d   = fall_b & ~filt[IDX_A] & ~fall_a;
         coll_ev = (fall_a & (filt[IDX_B] | fall_b)) | (fall_b & filt[IDX_A]);
      end
      // No motion while windings are released
      if (filt[IDX_REL])
      begin
         fwd_d = 1'b0;
         rev_d = 1'b0;
      end
   end

   // ************************************************************
   // Winding, resolution and standstill current
   // ************************************************************
   assign busy = filt[IDX_A] | ((mode_q == MODE_TWO_PULSE) & filt[IDX_B]);

   always_comb
   begin
      wind_d = ~filt[IDX_REL];
      res_d  = filt[IDX_SEL] ? preset_b_q : preset_a_q;
      if (busy || fwd_d || rev_d)
         idle_cnt_d = 24'h00_0000;
      else if (idle_cnt_q < idle_lim_q)
         idle_cnt_d = idle_cnt_q + 24'h00_0001;
      else
         idle_cnt_d = idle_cnt_q;
      cut_d = ~busy & (idle_cnt_q >= idle_lim_q) & ~filt[IDX_OVR];
   end

   // ************************************************************
   // Wishbone slave
   // ************************************************************
   assign bus_wr = wb_cyc & wb_stb & ~ack_q & wb_we;

   always_comb
   begin
      ack_d      = wb_cyc & wb_stb & ~ack_q;
      mode_d     = mode_q;
      preset_a_d = preset_a_q;
      preset_b_d = preset_b_q;
      idle_lim_d = idle_lim_q;
      pos_d      = pos_q;
      coll_d     = coll_q;
      rdat_d     = rdat_q;
      if (fwd_q)
         pos_d = pos_q + 32'h0000_0001;
      else if (rev_q)
         pos_d = pos_q - 32'h0000_0001;
      if (bus_wr)
      begin
         if (wb_adr == ADR_CTRL)
         begin
            if (wb_sel[0])
               mode_d = spid_mode_e'(wb_dat_w[CTRL_MODE_BIT]);
         end
         else if (wb_adr == ADR_PRESET)
         begin
            if (wb_sel[0])
            begin
               preset_a_d = wb_dat_w[PRESET_A_LSB +: 4];
               preset_b_d = wb_dat_w[PRESET_B_LSB +: 4];
            end
         end
         else if (wb_adr == ADR_IDLE)
            idle_lim_d = 24'(merge({8'h00, idle_lim_q}, wb_dat_w, wb_sel));
         else if (wb_adr == ADR_STATUS)
         begin
            if (wb_sel[0] && wb_dat_w[STAT_COLL_BIT])
               coll_d = 1'b0;
         end
         else if (wb_adr == ADR_POS)
            pos_d = merge(pos_q, wb_dat_w, wb_sel);
      end
      // Set beats clear
      if (coll_ev)
         coll_d = 1'b1;
      if (ack_d && !wb_we)
      begin
         if (wb_adr == ADR_CTRL)
            rdat_d = {31'h0000_0000, mode_q};
         else if (wb_adr == ADR_PRESET)
            rdat_d = {24'h00_0000, preset_b_q, preset_a_q};
         else if (wb_adr == ADR_IDLE)
            rdat_d = {8'h00, idle_lim_q};
         else if (wb_adr == ADR_STATUS)
            rdat_d = {24'h00_0000, coll_q, wind_q, cut_q, filt};
         else if (wb_adr == ADR_POS)
            rdat_d = pos_q;
         else
            rdat_d = 32'h0000_0000;
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         mode_q     <= MODE_ONE_PULSE;
         preset_a_q <= PRESET_A_RST;
         preset_b_q <= PRESET_B_RST;
         idle_lim_q <= 24'(IDLE_RST_CYCLES);
         pos_q      <= POS_RST;
         coll_q     <= 1'b0;
         ack_q      <= 1'b0;
         rdat_q     <= 32'h0000_0000;
         prev_a_q   <= 1'b0;
         prev_b_q   <= 1'b0;
         fwd_q      <= 1'b0;
         rev_q      <= 1'b0;
         wind_q     <= 1'b1;
         cut_q      <= 1'b0;
         idle_cnt_q <= 24'h00_0000;
         res_q      <= PRESET_A_RST;
      end
      else if (clk_en)
      begin
         mode_q     <= mode_d;
         preset_a_q <= preset_a_d;
         preset_b_q <= preset_b_d;
         idle_lim_q <= idle_lim_d;
         pos_q      <= pos_d;
         coll_q     <= coll_d;
         ack_q      <= ack_d;
         rdat_q     <= rdat_d;
         prev_a_q   <= filt[IDX_A];
         prev_b_q   <= filt[IDX_B];
         fwd_q      <= fwd_d;
         rev_q      <= rev_d;
         wind_q     <= wind_d;
         cut_q      <= cut_d;
         idle_cnt_q <= idle_cnt_d;
         res_q      <= res_d;
      end
   end

   assign wb_ack          = ack_q;
   assign wb_dat_r        = rdat_q;
   assign step_fwd        = fwd_q;
   assign step_rev        = rev_q;
   assign winding_en      = wind_q;
   assign current_cutback = cut_q;
   assign step_size_sel   = res_q;

   // ************************************************************
   // Assertions
   // ************************************************************
   sequence s_one_fwd;
      clk_en && (mode_q == MODE_ONE_PULSE) && fall_a && filt[IDX_B] && !filt[IDX_REL];
   endsequence
   sequence s_one_rev;
      clk_en && (mode_q == MODE_ONE_PULSE) && fall_a && !filt[IDX_B] && !filt[IDX_REL];
   endsequence

   AST_ONE_FWD: assert property (@(posedge core_clk) disable iff (sys_rst)
      s_one_fwd |=> step_fwd && !step_rev)
      else $error("one-pulse forward step missing");

   AST_ONE_REV: assert property (@(posedge core_clk) disable iff (sys_rst)
      s_one_rev |=> step_rev && !step_fwd)
      else $error("one-pulse reverse step missing");

   AST_DIR_NO_STEP: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && (mode_q == MODE_ONE_PULSE) && !fall_a |=> !step_fwd && !step_rev)
      else $error("direction line stepped in one-pulse mode");

   AST_TWO_FWD: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && (mode_q == MODE_TWO_PULSE) && fall_a && !filt[IDX_B] && !fall_b
      && !filt[IDX_REL] |=> step_fwd)
      else $error("two-pulse forward step missing");

   AST_TWO_REV: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && (mode_q == MODE_TWO_PULSE) && fall_b && !filt[IDX_A] && !fall_a
      && !filt[IDX_REL] |=> step_rev)
      else $error("two-pulse reverse step missing");

   AST_ONE_STEP: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && (step_fwd || step_rev) ##1 clk_en |-> !step_fwd && !step_rev)
      else $error("step pulse longer than one cycle");

   AST_RELEASE: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && (filt[IDX_REL] != $past(filt[IDX_REL])) |=> winding_en == !$past(filt[IDX_REL]))
      else $error("winding current not following release input");

   AST_RESOL: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && filt[IDX_SEL] |=> step_size_sel == $past(preset_b_q))
      else $error("step size not preset b");

   AST_CUTBACK: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && busy |=> !current_cutback)
      else $error("current reduced while pulse line conducts");

endmodule : spid_decoder

// ---- testbench/spid_ctrl_model.sv ----
`timescale 1ns/10ps
module spid_ctrl_model
(
   input  wire logic core_clk,
   output logic      step_line,
   output logic      dir_line
);

   // ************************************************************
   // Motion controller, 1 = opto conducting
   // ************************************************************
   initial
   begin
      step_line = 1'b0;
      dir_line  = 1'b0;
   end

   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
   endtask : idle

   task automatic drive(input logic s, input logic d);
      @(posedge core_clk);
      step_line <= s;
      dir_line  <= d;
   endtask : drive

   // Direction settles before the pulse, step line left off afterwards, direction line held
   task automatic one_step(input logic fwd, input int hold);
      drive(1'b0, fwd);
      idle(hold);
      drive(1'b1, fwd);
      idle(hold);
      drive(1'b0, fwd);
      idle(hold);
   endtask : one_step

   task automatic two_step(input logic fwd, input int hold);
      drive(fwd, !fwd);
      idle(hold);
      drive(1'b0, 1'b0);
      idle(hold);
   endtask : two_step

   // Deliberate fault: both lines pulse together
   task automatic both(input int hold);
      drive(1'b1, 1'b1);
      idle(hold);
      drive(1'b0, 1'b0);
      idle(hold);
   endtask : both

endmodule : spid_ctrl_model

// ---- testbench/tb_top.sv ----
`timescale 1ns/10ps
module tb_top
   import spid_pkg::*;
;

   localparam int unsigned IDLE_N = 50;

   logic        core_clk;
   logic        sys_rst;
   logic        clk_en;
   logic        wb_cyc;
   logic        wb_stb;
   logic        wb_we;
   logic [7:0]  wb_adr;
   logic [3:0]  wb_sel;
   logic [31:0] wb_dat_w;
   logic [31:0] wb_dat_r;
   logic        wb_ack;
   wire logic   step_in;
   wire logic   dir_in;
   logic        winding_release_in;
   logic        step_size_sel_in;
   logic        ovr_in;
   logic        step_fwd;
   logic        step_rev;
   logic        winding_en;
   logic        current_cutback;
   logic [3:0]  step_size_sel;
   int          failures;
   int          tests_run;
   int          seed;
   int          pos_m;
   int          nf;
   int          nr;
   int          ef;
   int          er;
   int          hold;
   logic        fwd;
   logic [31:0] rd;
   logic [7:0]  pa;

   spid_decoder #(.IDLE_RST_CYCLES(IDLE_N)) i_spid_decoder
   (
      .core_clk                         (core_clk),
      .sys_rst                          (sys_rst),
      .clk_en                           (clk_en),
      .wb_cyc                           (wb_cyc),
      .wb_stb                           (wb_stb),
      .wb_we                            (wb_we),
      .wb_adr                           (wb_adr),
      .wb_sel                           (wb_sel),
      .wb_dat_w                         (wb_dat_w),
      .wb_dat_r                         (wb_dat_r),
      .wb_ack                           (wb_ack),
      .step_pulse_in                    (step_in),
      .direction_in                     (dir_in),
      .winding_release_in               (winding_release_in),
      .step_size_sel_in                 (step_size_sel_in),
      .idle_current_cutback_override_in (ovr_in),
      .step_fwd                         (step_fwd),
      .step_rev                         (step_rev),
      .winding_en                       (winding_en),
      .current_cutback                  (current_cutback),
      .step_size_sel                    (step_size_sel)
   );

   spid_ctrl_model i_ctrl
   (
      .core_clk  (core_clk),
      .step_line (step_in),
      .dir_line  (dir_in)
   );

   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   always @(posedge core_clk)
   begin
      if (step_fwd === 1'b1) nf++;
      if (step_rev === 1'b1) nr++;
   end

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         failures++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int n;
      n = 0;
      @(posedge core_clk);
      wb_cyc   <= 1'b1;
      wb_stb   <= 1'b1;
      wb_we    <= we;
      wb_sel   <= 4'hF;
      wb_adr   <= adr;
      wb_dat_w <= dat;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (wb_ack !== 1'b1 && n < 100);
      rd = wb_dat_r;
      if (n >= 100) failures++;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask : wb

   task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
      wb(1'b0, adr, 32'h0);
      check(rd, exp);
   endtask : rd_chk

   task automatic wait_n(input int n);
      repeat (n) @(posedge core_clk);
   endtask : wait_n

   task automatic steps(input logic two);
      repeat (6)
      begin
         fwd  = 1'($random(seed));
         hold = 26 + ($random(seed) & 15);
         if (two) i_ctrl.two_step(fwd, hold);
         else i_ctrl.one_step(fwd, hold);
         if (fwd) ef++;
         else er++;
         pos_m += fwd ? 1 : -1;
         check(nf, ef);
         check(nr, er);
      end
   endtask : steps

   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test

   initial
   begin
      #(50 * 40000);
      failures++;
      stop_test;
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial
   begin
      seed = 32'h512A;
      {failures, tests_run, pos_m, nf, nr, ef, er} = '0;
      {sys_rst, clk_en} = 2'b11;
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w} = '0;
      wb_sel = 4'hF;
      {winding_release_in, step_size_sel_in, ovr_in} = 3'b000;
      wait_n(2);
      sys_rst <= 1'b0;
      wait_n(1);
      check(winding_en, 32'h1);
      check(current_cutback, 32'h0);
      check(step_size_sel, 32'h0);
      rd_chk(ADR_CTRL, 32'h0);
      rd_chk(ADR_POS, POS_RST);
      rd_chk(8'h20, 32'h0);
      steps(1'b0);
      rd_chk(ADR_POS, 32'(pos_m));
      // Direction settles alone before the glitch
      i_ctrl.drive(1'b0, 1'b1);
      wait_n(30);
      i_ctrl.drive(1'b1, 1'b1);
      wait_n(5);
      i_ctrl.drive(1'b0, 1'b1);
      wait_n(40);
      check(nf, ef);
      check(nr, er);
      wait_n(IDLE_N + 30);
      check(current_cutback, 32'h1);
      ovr_in <= 1'b1;
      wait_n(30);
      check(current_cutback, 32'h0);
      ovr_in <= 1'b0;
      wait_n(IDLE_N + 30);
      i_ctrl.drive(1'b1, 1'b1);
      wait_n(30);
      check(current_cutback, 32'h0);
      i_ctrl.drive(1'b0, 1'b1);
      ef++;
      pos_m++;
      wait_n(30);
      check(nf, ef);
      // Frozen while clock enable is low
      clk_en <= 1'b0;
      winding_release_in <= 1'b1;
      wait_n(30);
      check(winding_en, 32'h1);
      clk_en <= 1'b1;
      wait_n(30);
      check(winding_en, 32'h0);
      i_ctrl.one_step(1'b1, 30);
      check(nf, ef);
      winding_release_in <= 1'b0;
      wait_n(30);
      check(winding_en, 32'h1);
      pa = 8'($random(seed));
      wb(1'b1, ADR_PRESET, {24'h0, pa});
      wait_n(30);
      check(step_size_sel, pa[3:0]);
      step_size_sel_in <= 1'b1;
      wait_n(30);
      check(step_size_sel, pa[7:4]);
      i_ctrl.drive(1'b0, 1'b0);
      wait_n(30);
      wb(1'b1, ADR_CTRL, 32'h1);
      rd_chk(ADR_CTRL, 32'h1);
      steps(1'b1);
      i_ctrl.both(30);
      check(nf, ef);
      check(nr, er);
      wb(1'b0, ADR_STATUS, 32'h0);
      check(rd & 32'h80, 32'h80);
      wb(1'b1, ADR_STATUS, 32'h80);
      wb(1'b0, ADR_STATUS, 32'h0);
      check(rd & 32'h80, 32'h0);
      pos_m = $random(seed);
      wb(1'b1, ADR_POS, 32'(pos_m));
      i_ctrl.two_step(1'b0, 30);
      pos_m--;
      rd_chk(ADR_POS, 32'(pos_m));
      wb(1'b1, 8'h20, 32'hFFFF_FFFF);
      rd_chk(ADR_CTRL, 32'h1);
      // Second reset in mid-run
      sys_rst <= 1'b1;
      wait_n(2);
      sys_rst <= 1'b0;
      wait_n(1);
      rd_chk(ADR_CTRL, 32'h0);
      rd_chk(ADR_POS, POS_RST);
      stop_test;
   end

endmodule : tb_top
